// >>> rtl/cfg_bank_pkg.sv
// Purpose: Shared constants for the clock buffer configuration bank
// Assumes: Three-wire serial write-only link, 32-bit words, MSB first
// Notes: Fields named by function; offsets are bit positions in the word
// Function
// - Defaults load at power-on and on reset bit
// - Word 0 bit 4 reset, writing one restores defaults
// - Word 0 bit 5 global power-down
// - Word 0 bits 6-9 group power-downs
// - Word 0 bits 10-11 input buffer kinds, default bipolar
// - Input divide values bits 14-16, 19-21, default two
// - Divider selectors bits 17-18, 22-23, default bypass
// - Word 1 output formats bits 4-6, 7-9, default one
// - Word is 32 bits, address low nibble, MSB first
// - Strobe low while shifting, rising-edge capture, then pulse
// - Reset write ignores rest of that word
// - Reset bit clears on any other write to a mapped word; words 6-14 leave it set
package cfg_bank_pkg;
  localparam int WORD_BITS = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 3;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [3:0] ADDR_SETUP = 4'h0;
  localparam logic [3:0] ADDR_FMT_A = 4'h1;
  localparam logic [3:0] ADDR_FMT_B = 4'h2;
  localparam logic [3:0] ADDR_SYNC = 4'h3;
  localparam logic [3:0] ADDR_DDLY = 4'h4;
  localparam logic [3:0] ADDR_ODIV = 4'h5;
  localparam logic [3:0] ADDR_LOCK = 4'hF;
  localparam int RESET_BIT = 4;
  localparam int PWRDN_BIT = 5;
  localparam int GRP_A_LO_BIT = 6;
  localparam int GRP_A_HI_BIT = 7;
  localparam int GRP_B_LO_BIT = 8;
  localparam int GRP_B_HI_BIT = 9;
  localparam int IN0_BUF_BIT = 10;
  localparam int IN1_BUF_BIT = 11;
  localparam int IN0_DIV_LSB = 14;
  localparam int IN0_SEL_LSB = 17;
  localparam int IN1_DIV_LSB = 19;
  localparam int IN1_SEL_LSB = 22;
  localparam int OUT0_FMT_LSB = 4;
  localparam int OUT1_FMT_LSB = 7;
  localparam logic [2:0] DIV_DEFAULT = 3'h2;
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [2:0] FMT_DEFAULT = 3'h1;
endpackage

// >>> rtl/sync_bit.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level from another domain
// Notes: First stage feeds only the second
module sync_bit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// >>> rtl/serial_shifter.sv
// Purpose: Link-side shift register on the serial clock
// Assumes: Data captured on rising shift-clock edges, MSB first
// Notes: Word is held stable while the strobe is high
module serial_shifter
  import cfg_bank_pkg::*;
(
  input wire logic shiftClk,
  input wire logic rst_n,
  input wire logic serialData,
  input wire logic latchStrobe,
  output logic [WORD_BITS-1:0] shiftWord
);
  logic [WORD_BITS-1:0] next_shiftWord;
  always_comb begin
    next_shiftWord = shiftWord;
    // Shift only while the strobe is low so the word stays put for the core
    if (!latchStrobe) begin
      next_shiftWord = {shiftWord[WORD_BITS-2:0], serialData};
    end
  end
  always_ff @(posedge shiftClk or negedge rst_n) begin
    if (!rst_n) begin
      shiftWord <= '0;
    end else begin
      shiftWord <= next_shiftWord;
    end
  end
endmodule

// >>> rtl/clock_buffer_config_registers.sv
// Purpose: Configuration register bank loaded over the serial link
// Assumes: Shift clock stops or strobe high long enough to cross (>=3 sys_clk)
// Notes: Only the fields for reset, power, inputs and outputs 0/1 drive outputs
module clock_buffer_config_registers
  import cfg_bank_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shiftClk,
  input wire logic serialData,
  input wire logic latch_strobe,
  output logic resetControl,
  output logic globalPowerdown,
  output logic group_a_low_powerdown,
  output logic group_a_high_powerdown,
  output logic group_b_low_powerdown,
  output logic group_b_high_powerdown,
  output logic input0_buffer_kind,
  output logic input1_buffer_kind,
  output logic [2:0] input0_divide_value,
  output logic [2:0] input1_divide_value,
  output logic [1:0] input0_divider_select,
  output logic [1:0] input1_divider_select,
  output logic [2:0] output0_format,
  output logic [2:0] output1_format,
  output logic writeStrobe
);
  logic [WORD_BITS-1:0] shiftWord;
  logic strobeSync;
  logic strobePrev;
  logic [WORD_BITS-1:0] capWord;
  logic [WORD_BITS-1:0] next_capWord;
  logic next_writeStrobe;
  logic next_resetControl, next_globalPowerdown;
  logic next_gal, next_gah, next_gbl, next_gbh;
  logic next_buf0, next_buf1;
  logic [2:0] next_div0, next_div1, next_fmt0, next_fmt1;
  logic [1:0] next_sel0, next_sel1;
  logic [3:0] addr;
  logic latchRise;

  // Decode shared by the update logic and the checks below
  function automatic logic is_mapped(input logic [3:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_SETUP) begin
      hit = 1'b1;
    end else if (a == ADDR_FMT_A) begin
      hit = 1'b1;
    end else if (a == ADDR_FMT_B) begin
      hit = 1'b1;
    end else if (a == ADDR_SYNC) begin
      hit = 1'b1;
    end else if (a == ADDR_DDLY) begin
      hit = 1'b1;
    end else if (a == ADDR_ODIV) begin
      hit = 1'b1;
    end else if (a == ADDR_LOCK) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // A reset word loads defaults and nothing else
  function automatic logic is_reset_word(input logic [WORD_BITS-1:0] w);
    return (w[ADDR_MSB:ADDR_LSB] == ADDR_SETUP) && w[RESET_BIT];
  endfunction

  function automatic logic is_setup_load(input logic [WORD_BITS-1:0] w);
    return (w[ADDR_MSB:ADDR_LSB] == ADDR_SETUP) && !w[RESET_BIT];
  endfunction

  serial_shifter shifter (
    .shiftClk(shiftClk),
    .rst_n(rst_n),
    .serialData(serialData),
    .latchStrobe(latch_strobe),
    .shiftWord(shiftWord)
  );

  sync_bit strobeSyncer (
    .clk(sys_clk),
    .rst_n(rst_n),
    .din(latch_strobe),
    .dout(strobeSync)
  );

  // Word is stable while strobe high; sampling after two flops avoids tearing
  assign latchRise = strobeSync && !strobePrev;
  assign addr = capWord[ADDR_MSB:ADDR_LSB];

  always_comb begin
    next_capWord = latchRise ? shiftWord : capWord;
    next_writeStrobe = latchRise;
    next_resetControl = resetControl;
    next_globalPowerdown = globalPowerdown;
    next_gal = group_a_low_powerdown;
    next_gah = group_a_high_powerdown;
    next_gbl = group_b_low_powerdown;
    next_gbh = group_b_high_powerdown;
    next_buf0 = input0_buffer_kind;
    next_buf1 = input1_buffer_kind;
    next_div0 = input0_divide_value;
    next_div1 = input1_divide_value;
    next_sel0 = input0_divider_select;
    next_sel1 = input1_divider_select;
    next_fmt0 = output0_format;
    next_fmt1 = output1_format;
    if (writeStrobe) begin
      if (is_reset_word(capWord)) begin
        // Restore defaults, rest of word ignored
        next_resetControl = 1'b1;
        next_globalPowerdown = 1'b0;
        next_gal = 1'b0;
        next_gah = 1'b0;
        next_gbl = 1'b0;
        next_gbh = 1'b0;
        next_buf0 = 1'b0;
        next_buf1 = 1'b0;
        next_div0 = DIV_DEFAULT;
        next_div1 = DIV_DEFAULT;
        next_sel0 = SEL_DEFAULT;
        next_sel1 = SEL_DEFAULT;
        next_fmt0 = FMT_DEFAULT;
        next_fmt1 = FMT_DEFAULT;
      end else if (addr == ADDR_SETUP) begin
        next_resetControl = 1'b0;
        next_globalPowerdown = capWord[PWRDN_BIT];
        next_gal = capWord[GRP_A_LO_BIT];
        next_gah = capWord[GRP_A_HI_BIT];
        next_gbl = capWord[GRP_B_LO_BIT];
        next_gbh = capWord[GRP_B_HI_BIT];
        next_buf0 = capWord[IN0_BUF_BIT];
        next_buf1 = capWord[IN1_BUF_BIT];
        next_div0 = capWord[IN0_DIV_LSB +: 3];
        next_div1 = capWord[IN1_DIV_LSB +: 3];
        next_sel0 = capWord[IN0_SEL_LSB +: 2];
        next_sel1 = capWord[IN1_SEL_LSB +: 2];
      end else if (addr == ADDR_FMT_A) begin
        next_resetControl = 1'b0;
        next_fmt0 = capWord[OUT0_FMT_LSB +: 3];
        next_fmt1 = capWord[OUT1_FMT_LSB +: 3];
      end else if (is_mapped(addr)) begin
        // Fields of these words are not held here
        next_resetControl = 1'b0;
      end
      // Other addresses change nothing
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Power-on defaults
      strobePrev <= 1'b0;
      capWord <= '0;
      writeStrobe <= 1'b0;
      resetControl <= 1'b0;
      globalPowerdown <= 1'b0;
      group_a_low_powerdown <= 1'b0;
      group_a_high_powerdown <= 1'b0;
      group_b_low_powerdown <= 1'b0;
      group_b_high_powerdown <= 1'b0;
      input0_buffer_kind <= 1'b0;
      input1_buffer_kind <= 1'b0;
      input0_divide_value <= DIV_DEFAULT;
      input1_divide_value <= DIV_DEFAULT;
      input0_divider_select <= SEL_DEFAULT;
      input1_divider_select <= SEL_DEFAULT;
      output0_format <= FMT_DEFAULT;
      output1_format <= FMT_DEFAULT;
    end else begin
      strobePrev <= strobeSync;
      capWord <= next_capWord;
      writeStrobe <= next_writeStrobe;
      resetControl <= next_resetControl;
      globalPowerdown <= next_globalPowerdown;
      group_a_low_powerdown <= next_gal;
      group_a_high_powerdown <= next_gah;
      group_b_low_powerdown <= next_gbl;
      group_b_high_powerdown <= next_gbh;
      input0_buffer_kind <= next_buf0;
      input1_buffer_kind <= next_buf1;
      input0_divide_value <= next_div0;
      input1_divide_value <= next_div1;
      input0_divider_select <= next_sel0;
      input1_divider_select <= next_sel1;
      output0_format <= next_fmt0;
      output1_format <= next_fmt1;
    end
  end

  reset_defaults_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_SETUP && capWord[RESET_BIT] |=> resetControl
    && input0_divide_value == DIV_DEFAULT && output0_format == FMT_DEFAULT)
    else $error("reset write did not restore defaults");
  reset_ignores_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_SETUP && capWord[RESET_BIT] |=> !globalPowerdown
    && !group_a_low_powerdown && input1_divider_select == SEL_DEFAULT)
    else $error("reset write took other fields");
  reset_autoclear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr != ADDR_SETUP && addr <= ADDR_ODIV |=> !resetControl)
    else $error("reset bit not cleared");
  pwrdn_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_SETUP && !capWord[RESET_BIT]
    |=> globalPowerdown == $past(capWord[PWRDN_BIT]))
    else $error("power-down not loaded");
  group_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_SETUP && !capWord[RESET_BIT]
    |=> group_b_high_powerdown == $past(capWord[GRP_B_HI_BIT])
    && input1_buffer_kind == $past(capWord[IN1_BUF_BIT]))
    else $error("group or buffer field not loaded");
  divider_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_SETUP && !capWord[RESET_BIT]
    |=> input1_divide_value == $past(capWord[IN1_DIV_LSB +: 3])
    && input0_divider_select == $past(capWord[IN0_SEL_LSB +: 2]))
    else $error("divider fields not loaded");
  format_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_FMT_A
    |=> output1_format == $past(capWord[OUT1_FMT_LSB +: 3]))
    else $error("output format not loaded");
  unmapped_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr > ADDR_ODIV && addr != ADDR_LOCK
    |=> $stable(resetControl) && $stable(output0_format))
    else $error("unmapped write changed state");
  latch_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe |=> !writeStrobe)
    else $error("write strobe longer than one cycle");

  // Field checks; the captured word is stable while writeStrobe stands
  strobe_to_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    latchRise |=> writeStrobe)
    else $error("strobe rise not applied");
  write_from_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe |-> $past(latchRise))
    else $error("write strobe without strobe rise");
  word_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    latchRise |=> capWord == $past(shiftWord))
    else $error("shifted word not captured");
  quiet_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !writeStrobe |=> $stable(resetControl) && $stable(globalPowerdown)
    && $stable(input0_divide_value) && $stable(output1_format))
    else $error("state changed without a write");
  setup_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord) |=> !resetControl)
    else $error("setup write kept reset bit");
  lock_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_LOCK |=> !resetControl)
    else $error("lock word write kept reset bit");
  group_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> group_a_low_powerdown == $past(capWord[GRP_A_LO_BIT])
    && group_b_low_powerdown == $past(capWord[GRP_B_LO_BIT]))
    else $error("low group power-down not loaded");
  group_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> group_a_high_powerdown == $past(capWord[GRP_A_HI_BIT]))
    else $error("high group power-down not loaded");
  buffer0_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> input0_buffer_kind == $past(capWord[IN0_BUF_BIT]))
    else $error("input 0 buffer kind not loaded");
  divider0_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> input0_divide_value == $past(capWord[IN0_DIV_LSB +: 3]))
    else $error("input 0 divide value not loaded");
  select1_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> input1_divider_select == $past(capWord[IN1_SEL_LSB +: 2]))
    else $error("input 1 divider select not loaded");
  select0_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_setup_load(capWord)
    |=> input0_divider_select == $past(capWord[IN0_SEL_LSB +: 2]))
    else $error("input 0 divider select not loaded");
  reset_groups_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_reset_word(capWord)
    |=> !group_a_high_powerdown && !group_b_low_powerdown && !group_b_high_powerdown
    && !input0_buffer_kind && !input1_buffer_kind)
    else $error("reset write left group or buffer fields");
  reset_dividers_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_reset_word(capWord)
    |=> input1_divide_value == DIV_DEFAULT && input0_divider_select == SEL_DEFAULT
    && output1_format == FMT_DEFAULT)
    else $error("reset write left divider or format fields");
  format0_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_FMT_A
    |=> output0_format == $past(capWord[OUT0_FMT_LSB +: 3]))
    else $error("output 0 format not loaded");
  format_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr != ADDR_FMT_A && !is_reset_word(capWord)
    |=> $stable(output0_format) && $stable(output1_format))
    else $error("output format changed by another word");
  setup_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr != ADDR_SETUP
    |=> $stable(globalPowerdown) && $stable(group_a_low_powerdown)
    && $stable(input0_divide_value))
    else $error("setup fields changed by another word");
  unmapped_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && !is_mapped(addr)
    |=> $stable(resetControl) && $stable(input1_buffer_kind))
    else $error("unmapped write changed stored bits");
  reset_sets_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && is_reset_word(capWord) |=> resetControl)
    else $error("reset bit not stored");
  pwrdn_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStrobe && addr == ADDR_FMT_A |=> $stable(globalPowerdown))
    else $error("format write changed power-down");
endmodule

// >>> test/host_serial_model.sv
// Purpose: Host side of the three-wire serial link
// Assumes: 30 ns shift clock, running only inside a frame
// Notes: Data line shows the inverted last bit once released
module host_serial_model (
  output logic shiftClk,
  output logic serialData,
  output logic latchStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shiftClk = 1'b0;
    serialData = 1'b0;
    latchStrobe = 1'b0;
  end
  task automatic send_word(input logic [31:0] w);
    #7;
    for (int i = 31; i >= 0; i--) begin
      serialData = w[i];
      #15 shiftClk = 1'b1;
      #15 shiftClk = 1'b0;
    end
    // Inverted so a late sample cannot pass by luck
    serialData = ~w[0];
    #15 latchStrobe = 1'b1;
    #60 latchStrobe = 1'b0;
    #30;
  endtask
endmodule

// >>> test/clock_buffer_config_registers_tb.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Host model drives the link; fields read straight off the ports
// Notes: Word 0 fields are packed back into their bit positions to compare
module clock_buffer_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DEF0 = 32'h0010_8000;
  logic sys_clk, rst_n, shiftClk, serialData, latchStrobe, writeStrobe;
  logic resetControl, globalPowerdown, input0_buffer_kind, input1_buffer_kind;
  logic group_a_low_powerdown, group_a_high_powerdown;
  logic group_b_low_powerdown, group_b_high_powerdown;
  logic [2:0] input0_divide_value, input1_divide_value, output0_format, output1_format;
  logic [1:0] input0_divider_select, input1_divider_select;
  logic [31:0] img0;
  logic [5:0] fmt;
  int err_total = 0;
  int cmp_count = 0;
  assign img0 = {8'h00, input1_divider_select, input1_divide_value, input0_divider_select,
    input0_divide_value, 2'b00, input1_buffer_kind, input0_buffer_kind,
    group_b_high_powerdown, group_b_low_powerdown, group_a_high_powerdown,
    group_a_low_powerdown, globalPowerdown, resetControl, 4'h0};
  assign fmt = {output1_format, output0_format};
  host_serial_model host_u (
    .shiftClk(shiftClk),
    .serialData(serialData),
    .latchStrobe(latchStrobe)
  );
  clock_buffer_config_registers dut_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .shiftClk(shiftClk),
    .serialData(serialData),
    .latch_strobe(latchStrobe),
    .resetControl(resetControl),
    .globalPowerdown(globalPowerdown),
    .group_a_low_powerdown(group_a_low_powerdown),
    .group_a_high_powerdown(group_a_high_powerdown),
    .group_b_low_powerdown(group_b_low_powerdown),
    .group_b_high_powerdown(group_b_high_powerdown),
    .input0_buffer_kind(input0_buffer_kind),
    .input1_buffer_kind(input1_buffer_kind),
    .input0_divide_value(input0_divide_value),
    .input1_divide_value(input1_divide_value),
    .input0_divider_select(input0_divider_select),
    .input1_divider_select(input1_divider_select),
    .output0_format(output0_format),
    .output1_format(output1_format),
    .writeStrobe(writeStrobe)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits on the apply pulse under a bound instead of a fixed delay
  task automatic put(input logic [31:0] w);
    bit seen;
    seen = 1'b0;
    fork
      host_u.send_word(w);
      for (int n = 0; n < 400 && !seen; n++) begin
        @(posedge sys_clk);
        #1 seen = (writeStrobe === 1'b1);
      end
    join
    chk("write strobe", 32'h1, {31'h0, seen});
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_defaults;
    chk("word0 defaults", DEF0, img0);
    chk("format defaults", 32'h09, {26'h0, fmt});
  endtask
  task automatic t_setup;
    put(32'hFFFF_FFE0);
    chk("word0 fields", 32'h00FF_CFE0, img0);
  endtask
  task automatic t_formats;
    put(32'h0000_02B1);
    chk("output formats", 32'h2B, {26'h0, fmt});
    chk("word0 kept", 32'h00FF_CFE0, img0);
  endtask
  task automatic t_unmapped;
    for (int a = 6; a < 15; a++) begin
      put(32'hFFFF_FFF0 | 32'(a));
      chk("unmapped word0", 32'h00FF_CFE0, img0);
      chk("unmapped formats", 32'h2B, {26'h0, fmt});
    end
  endtask
  task automatic t_reset;
    put(32'hFFFF_FFF0);
    chk("reset word0", DEF0 | 32'h10, img0);
    chk("reset formats", 32'h09, {26'h0, fmt});
    put(32'h0000_0003);
    chk("clear by word3", DEF0, img0);
    put(32'hFFFF_FFF0);
    put(DEF0);
    chk("clear by word0", DEF0, img0);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_defaults();
    t_setup();
    t_formats();
    t_unmapped();
    t_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
